// ===== rcb_pkg.sv
// Purpose: Shared constants for the registered command buffer with parity
// Assumes: One clock, asynchronous active-high reset
// Notes:   All widths and the data, select, drive and error reset values live here
package rcb_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned DATA_W = 22;
    localparam int unsigned CKE_W  = 2;
    localparam int unsigned ODT_W  = 2;
    localparam int unsigned CS_W   = 4;

    // ==========================================================
    // Field positions inside the chip select vector
    localparam int unsigned CS_IN0_POS = 0;
    localparam int unsigned CS_IN1_POS = 1;
    localparam int unsigned CS_EX0_POS = 2;
    localparam int unsigned CS_EX1_POS = 3;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST   = 22'h000000;
    localparam logic              OUT_RST    = 1'b0;
    localparam logic              ERR_N_RST  = 1'b1;
    localparam logic              ERR_OE_RST = 1'b0;

    // ==========================================================
    // Timing counts, in clock cycles
    localparam int unsigned PARITY_LAG_CYC = 1;
    localparam int unsigned ERR_DELAY_CYC  = 1;
    localparam int unsigned ERR_HOLD_CYC   = 2;

endpackage

// ===== rcb_cap_if.sv
// Purpose: Carries capture-side results to the parity checker
// Assumes: Driven combinationally by the capture module
// Notes:   One producer, one consumer
`timescale 1ns/1ps

interface rcb_cap_if;
    logic cs_active;
    logic data_odd;

    modport src
    (
        output cs_active,
        output data_odd
    );

    modport dst
    (
        input  cs_active,
        input  data_odd
    );
endinterface

// ===== rcb_capture.sv
// Purpose: Chip-select gated capture of the data inputs
// Assumes: Inputs synchronous to clk_sys_i
// Notes:   Holds the last word when gating blocks a capture
`timescale 1ns/1ps

module rcb_capture
    import rcb_pkg::*;
#(
    parameter int unsigned DW = DATA_W
)
(
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    input  wire logic [DW-1:0] data_i,
    input  wire logic [CS_W-1:0] cs_n_i,
    input  wire logic          gate_en_i,
    output logic      [DW-1:0] data_o,
    rcb_cap_if.src             cap
);

    // ==========================================================
    // Gating decision
    logic          load;
    logic [DW-1:0] data_reg;

    // Any of the four selects low marks a valid command cycle
    assign cap.cs_active = ~&cs_n_i;
    assign cap.data_odd  = ^data_i;
    // Gate off means every edge loads
    assign load = ~gate_en_i | cap.cs_active;

    // ==========================================================
    // Data register
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_reg <= DW'(DATA_RST);
        end
        else if (load)
        begin
            data_reg <= data_i;
        end
    end

    assign data_o = data_reg;

endmodule

// ===== rcb_parity.sv
// Purpose: Parity check with delayed, stretched open-drain error
// Assumes: Parity bit arrives one cycle after its data word
// Notes:   Error pin only ever pulls low; oe high while pulling
`timescale 1ns/1ps

module rcb_parity
    import rcb_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic parity_i,
    rcb_cap_if.dst    cap,
    output logic      err_n_o,
    output logic      err_oe_o
);

    // ==========================================================
    // Pipeline registers
    logic odd_reg;
    logic valid_reg;
    logic mismatch_reg;
    logic stretch_reg;
    logic err_n_reg;
    logic err_oe_reg;

    // Hold the word's parity until its parity bit shows up
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            odd_reg   <= 1'b0;
            valid_reg <= 1'b0;
        end
        else
        begin
            odd_reg   <= cap.data_odd;
            valid_reg <= cap.cs_active;
        end
    end

    // Even parity expected; no select low means no check
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mismatch_reg <= 1'b0;
        end
        else
        begin
            mismatch_reg <= valid_reg & (odd_reg ^ parity_i);
        end
    end

    // ==========================================================
    // Output stage: one cycle late, low for two cycles
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stretch_reg <= 1'b0;
            err_n_reg   <= ERR_N_RST;
            err_oe_reg  <= ERR_OE_RST;
        end
        else
        begin
            stretch_reg <= mismatch_reg;
            err_n_reg   <= ~(mismatch_reg | stretch_reg);
            err_oe_reg  <= mismatch_reg | stretch_reg;
        end
    end

    assign err_n_o  = err_n_reg;
    assign err_oe_o = err_oe_reg;

endmodule

// ===== rcb_buffer.sv
// Purpose: 1:2 registered address/command buffer with parity check
// Assumes: clk_sys_i stands for the rising edge of the positive clock leg
// Notes:   Pull-ups on unconnected pins are resolved outside this module
`timescale 1ns/1ps

// Operation
// - Parity mismatch pulls error pin low
// - Error stays asserted two clock cycles
// - Error output lags comparison by one cycle
// - Gating on: capture only with select low
// - Gating off: capture on every edge
// - Drive select high normal, low high drive
// - Unconnected drive select reads high, normal
// - Capture on rising edge of clock
// - Reset clears storage, non-error outputs low immediately
// - Reset releases the parity error output
// - Data inputs re-driven only under gating
// - Clock enable and termination always registered
// - Extra selects gate and check, no outputs
module rcb_buffer
    import rcb_pkg::*;
#(
    parameter int unsigned DW   = DATA_W,
    parameter int unsigned CKEW = CKE_W,
    parameter int unsigned ODTW = ODT_W
)
(
    input  wire logic            clk_sys_i,
    input  wire logic            rst_i,
    input  wire logic [DW-1:0]   gated_data_in_i,
    input  wire logic            parity_in_i,
    input  wire logic            chip_select_in_0_i,
    input  wire logic            chip_select_in_1_i,
    input  wire logic            extra_chip_select_0_i,
    input  wire logic            extra_chip_select_1_i,
    input  wire logic            chip_select_gate_enable_i,
    input  wire logic            drive_strength_select_i,
    input  wire logic [CKEW-1:0] clk_enable_in_i,
    input  wire logic [ODTW-1:0] termination_in_i,
    output logic      [DW-1:0]   data_out_a_o,
    output logic      [DW-1:0]   data_out_b_o,
    output logic                 chip_select_out_0_a_o,
    output logic                 chip_select_out_0_b_o,
    output logic                 chip_select_out_1_a_o,
    output logic                 chip_select_out_1_b_o,
    output logic      [CKEW-1:0] clk_enable_out_a_o,
    output logic      [CKEW-1:0] clk_enable_out_b_o,
    output logic      [ODTW-1:0] termination_out_a_o,
    output logic      [ODTW-1:0] termination_out_b_o,
    output logic                 high_drive_o,
    output logic                 parity_error_n_o,
    output logic                 parity_error_oe_o
);

    // ==========================================================
    // Internal signals
    rcb_cap_if         cap ();
    logic [CS_W-1:0]   cs_n;
    logic [DW-1:0]     data_q;
    logic              cs0_reg;
    logic              cs1_reg;
    logic [CKEW-1:0]   cke_reg;
    logic [ODTW-1:0]   odt_reg;
    logic              high_drive_reg;

    assign cs_n[CS_IN0_POS] = chip_select_in_0_i;
    assign cs_n[CS_IN1_POS] = chip_select_in_1_i;
    assign cs_n[CS_EX0_POS] = extra_chip_select_0_i;
    assign cs_n[CS_EX1_POS] = extra_chip_select_1_i;

    // ==========================================================
    // Gated data path
    rcb_capture #(
        .DW        (DW)
    ) u_capture (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .data_i    (gated_data_in_i),
        .cs_n_i    (cs_n),
        .gate_en_i (chip_select_gate_enable_i),
        .data_o    (data_q),
        .cap       (cap.src)
    );

    // ==========================================================
    // Parity checker
    rcb_parity u_parity (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .parity_i  (parity_in_i),
        .cap       (cap.dst),
        .err_n_o   (parity_error_n_o),
        .err_oe_o  (parity_error_oe_o)
    );

    // ==========================================================
    // Ungated selects, clock enables and termination
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs0_reg <= OUT_RST;
            cs1_reg <= OUT_RST;
            cke_reg <= '0;
            odt_reg <= '0;
        end
        else
        begin
            cs0_reg <= chip_select_in_0_i;
            cs1_reg <= chip_select_in_1_i;
            cke_reg <= clk_enable_in_i;
            odt_reg <= termination_in_i;
        end
    end

    // ==========================================================
    // Drive strength; pad driver reads this level
    // Open input reads high via the pad pull-up, giving normal drive
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            high_drive_reg <= OUT_RST;
        end
        else
        begin
            high_drive_reg <= ~drive_strength_select_i;
        end
    end

    // ==========================================================
    // Duplicated copies share one flop so they can never diverge
    assign data_out_a_o          = data_q;
    assign data_out_b_o          = data_q;
    assign chip_select_out_0_a_o = cs0_reg;
    assign chip_select_out_0_b_o = cs0_reg;
    assign chip_select_out_1_a_o = cs1_reg;
    assign chip_select_out_1_b_o = cs1_reg;
    assign clk_enable_out_a_o    = cke_reg;
    assign clk_enable_out_b_o    = cke_reg;
    assign termination_out_a_o   = odt_reg;
    assign termination_out_b_o   = odt_reg;
    assign high_drive_o          = high_drive_reg;

endmodule

// ===== rcb_ctrl_model.sv
// Purpose: Controller side: presents words and their parity
// Assumes: Drives on the falling edge, away from the capture edge
// Notes:   bad_i flips parity on purpose to provoke errors
`timescale 1ns/1ps

module rcb_ctrl_model
    import rcb_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic [DATA_W-1:0] word_i,
    input  wire logic              bad_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   parity_o
);
    // ==========================================================
    // Word now, its even parity one cycle later
    always @(negedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_o   <= '0;
            parity_o <= 1'b0;
        end
        else
        begin
            parity_o <= ^data_o ^ bad_i;
            data_o   <= word_i;
        end
    end
endmodule

// ===== rcb_buffer_props.sv
// Purpose: Port-level checks on the command buffer
// Assumes: One clock, reset active high
// Notes:   Bound to every rcb_buffer instance
`timescale 1ns/1ps

module rcb_buffer_props
    import rcb_pkg::*;
#(
    parameter int unsigned DW   = DATA_W,
    parameter int unsigned CKEW = CKE_W
)
(
    input wire logic            clk_sys_i,
    input wire logic            rst_i,
    input wire logic [DW-1:0]   gated_data_in_i,
    input wire logic            parity_in_i,
    input wire logic            chip_select_in_0_i,
    input wire logic            chip_select_in_1_i,
    input wire logic            extra_chip_select_0_i,
    input wire logic            extra_chip_select_1_i,
    input wire logic            chip_select_gate_enable_i,
    input wire logic            drive_strength_select_i,
    input wire logic [CKEW-1:0] clk_enable_in_i,
    input wire logic [DW-1:0]   data_out_a_o,
    input wire logic [DW-1:0]   data_out_b_o,
    input wire logic            chip_select_out_0_a_o,
    input wire logic [CKEW-1:0] clk_enable_out_a_o,
    input wire logic            high_drive_o,
    input wire logic            parity_error_n_o,
    input wire logic            parity_error_oe_o
);
    wire cs_any = !(chip_select_in_0_i & chip_select_in_1_i
                    & extra_chip_select_0_i & extra_chip_select_1_i);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Assertions
    a_copy_same: assert property (
        data_out_a_o == data_out_b_o) else $error("copies differ");
    a_oe_follows: assert property (
        parity_error_oe_o != parity_error_n_o) else $error("oe wrong");
    a_err_hold: assert property (
        $fell(parity_error_n_o) |=> !parity_error_n_o)
        else $error("error pulse too short");
    a_err_timing: assert property (
        cs_any ##1 (^$past(gated_data_in_i) ^ parity_in_i)
        |-> ##2 !parity_error_n_o ##1 !parity_error_n_o)
        else $error("error pulse missing or late");
    a_gate_load: assert property (
        !$past(rst_i) && $past(!chip_select_gate_enable_i || cs_any)
        |-> data_out_a_o == $past(gated_data_in_i))
        else $error("data not captured");
    a_gate_hold: assert property (
        !$past(rst_i) && $past(chip_select_gate_enable_i && !cs_any)
        |-> $stable(data_out_a_o)) else $error("data changed");
    a_ungated_reg: assert property (
        !$past(rst_i) |-> clk_enable_out_a_o == $past(clk_enable_in_i)
        && chip_select_out_0_a_o == $past(chip_select_in_0_i))
        else $error("ungated output wrong");
    a_drive_sel: assert property (
        !$past(rst_i) |-> high_drive_o == !$past(drive_strength_select_i))
        else $error("drive level wrong");
    a_reset_out: assert property (disable iff (1'b0)
        rst_i |-> data_out_a_o == '0 && parity_error_n_o)
        else $error("reset outputs wrong");
endmodule

bind rcb_buffer rcb_buffer_props #(.DW(DW), .CKEW(CKEW)) i_props (.*);

// ===== rcb_buffer_tb.sv
// Purpose: Random plus corner-case run of the command buffer
// Assumes: Inputs change on the falling edge only
// Notes:   Reference model updates on the rising edge
`timescale 1ns/1ps

module rcb_buffer_tb
    import rcb_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i, chip_select_gate_enable_i, drive_strength_select_i, bad;
    logic [CKE_W-1:0] clk_enable_in_i, clk_enable_out_a_o, clk_enable_out_b_o;
    logic [ODT_W-1:0] termination_in_i, termination_out_a_o;
    logic [ODT_W-1:0] termination_out_b_o;
    logic [DATA_W-1:0] gated_data_in_i, data_out_a_o, data_out_b_o;
    logic [DATA_W-1:0] word, exp_d;
    logic chip_select_out_0_a_o, chip_select_out_0_b_o, parity_in_i;
    logic chip_select_out_1_a_o, chip_select_out_1_b_o, high_drive_o;
    logic parity_error_n_o, parity_error_oe_o, exp_hd, pend, odd, forced;
    logic [3:0] cs_v;
    logic [2:0] hist;
    logic [11:0] exp_u;
    logic [31:0] seed;
    int error_cnt, tests_run, i;
    wire chip_select_in_0_i = cs_v[0];
    wire chip_select_in_1_i = cs_v[1];
    wire extra_chip_select_0_i = cs_v[2];
    wire extra_chip_select_1_i = cs_v[3];

    always #2 clk_sys_i = ~clk_sys_i;
    rcb_buffer i_dut (.*);
    rcb_ctrl_model i_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .word_i(word), .bad_i(bad), .data_o(gated_data_in_i),
        .parity_o(parity_in_i));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic f_load(input logic g, input logic [3:0] c);
        return !g || (c != 4'hF);
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Reference: error low one and two edges after the comparison edge
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {exp_d, exp_u, exp_hd, hist, pend, odd} = '0;
        end
        else
        begin
            hist = {hist[1:0], pend & (odd ^ parity_in_i)};
            pend = cs_v != 4'hF;
            odd = ^gated_data_in_i;
            if (f_load(chip_select_gate_enable_i, cs_v))
                exp_d = gated_data_in_i;
            exp_u = {{2{cs_v[0]}}, {2{cs_v[1]}}, {2{clk_enable_in_i}},
                     {2{termination_in_i}}};
            exp_hd = !drive_strength_select_i;
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        {error_cnt, tests_run} = '0;
        word <= '0;
        bad <= 1'b0;
        {chip_select_gate_enable_i, drive_strength_select_i} = 2'h3;
        {clk_enable_in_i, termination_in_i} = '0;
        seed = 32'h285A3749;
        cs_v = 4'hF;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check({data_out_a_o, parity_error_n_o}, 32'h1);
        rst_i = 1'b0;
        for (i = 0; i < 400; i++)
        begin
            @(negedge clk_sys_i);
            check(data_out_a_o, exp_d);
            check(data_out_b_o, exp_d);
            check({chip_select_out_0_a_o, chip_select_out_0_b_o,
                chip_select_out_1_a_o, chip_select_out_1_b_o,
                clk_enable_out_a_o, clk_enable_out_b_o,
                termination_out_a_o, termination_out_b_o}, exp_u);
            check(high_drive_o, exp_hd);
            check({parity_error_n_o, parity_error_oe_o},
                {~(hist[2] | hist[1]), hist[2] | hist[1]});
            if (i == 200)
            begin
                rst_i = 1'b1;
                #1;
                check({data_out_a_o, parity_error_n_o}, 32'h1);
                repeat (2) @(negedge clk_sys_i);
                rst_i = 1'b0;
                $display("test mid reset done");
            end
            seed = xs(seed);
            // Back-to-back errors, and one still pending at the reset
            forced = (i >= 20 && i < 23) || (i >= 196 && i < 199);
            // Non-blocking so the model's falling-edge read is not a race
            word <= seed[21:0];
            bad <= forced | (seed[31] & seed[5]);
            cs_v = forced ? 4'hE : (seed[22] ? 4'hF : seed[26:23]);
            chip_select_gate_enable_i = seed[27];
            drive_strength_select_i = seed[28];
            clk_enable_in_i = seed[30:29];
            termination_in_i = seed[1:0] ^ seed[31:30];
        end
        $display("test random done");
        final_report();
    end
endmodule
